// *** rtl/rpgi_consts.vh ***
// Constants for the regulator power-good interrupt block.
`ifndef RPGI_CONSTS_VH
`define RPGI_CONSTS_VH
`define RPGI_AW              8
`define RPGI_DW              8
`define RPGI_ADDR_FALL_FLAGS 8'h3D
`define RPGI_ADDR_FALL_MASKS 8'h3E
`define RPGI_ADDR_EDGE_FLAGS 8'h3F
`define RPGI_ADDR_EDGE_MASKS 8'h40
`define RPGI_ADDR_IRQ_STAT   8'h50
`define RPGI_ADDR_IRQ_MASK   8'h51
`define RPGI_FALL_N          8
`define RPGI_EDGE_N          6
`define RPGI_MASK_RST        8'hFF
`define RPGI_FLAG_RST        8'h00
`define RPGI_IRQ_FALL_BIT    0
`define RPGI_IRQ_EDGE_BIT    1
`define RPGI_IRQ_N           2
`define RPGI_SETTLE_LAST     3'h4
`endif

// *** rtl/rpgi_sync.v ***
// Three-stage synchroniser with agreement check for pin inputs.
`timescale 1ns/1ps
`include "rpgi_consts.vh"
module rpgi_sync #(
    parameter W = 1
) (
    // Clock and reset.
    input  wire         clk_i,
    input  wire         rst_i,
    // Asynchronous input and filtered result.
    input  wire [W-1:0] async_i,
    output reg  [W-1:0] level_o
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;

    // The output only moves once stages two and three agree, so a metastable settle never yields a double edge.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1_q    <= {W{1'b0}};
            s2_q    <= {W{1'b0}};
            s3_q    <= {W{1'b0}};
            level_o <= {W{1'b0}};
        end
        else
        begin
            s1_q    <= async_i;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_o <= (s2_q & s3_q) | (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & level_o);
        end
    end
endmodule

// *** rtl/rpgi_edge.v ***
// Edge detector producing rise and fall pulses from a synchronised level.
`timescale 1ns/1ps
`include "rpgi_consts.vh"
module rpgi_edge #(
    parameter W = 1
) (
    // Clock and reset.
    input  wire         clk_i,
    input  wire         rst_i,
    // Level in, one-cycle pulses out.
    input  wire [W-1:0] level_i,
    output wire [W-1:0] rise_o,
    output wire [W-1:0] fall_o,
    output wire         primed_o
);
    reg [W-1:0] prev_q;
    reg         primed_q;
    reg  [2:0]  settle_q;

    // The synchroniser shows its reset zero for several cycles, so history is only trusted once it has settled.
    // Without this wait a pin that idles high would fake a rising edge just after every reset.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prev_q   <= {W{1'b0}};
            primed_q <= 1'b0;
            settle_q <= 3'h0;
        end
        else
        begin
            prev_q   <= level_i;
            primed_q <= primed_q | (settle_q == `RPGI_SETTLE_LAST);
            if (!primed_q)
                settle_q <= settle_q + 3'h1;
        end
    end

    assign rise_o   = {W{primed_q}} & level_i & ~prev_q;
    assign fall_o   = {W{primed_q}} & ~level_i & prev_q;
    assign primed_o = primed_q;
endmodule

// *** rtl/rpgi_top.v ***
// Power-good interrupt flags, masks and combined request for bucks and linear regulators.
//
// Notes on behaviour
// - Falling good of ldo1-4 sets bits 7:4.
// - Falling good of buck1-4 sets bits 3:0.
// - Fall detection gated by regulator enable bit.
// - Either edge of ldo5-10 sets bits 5:0.
// - Writing one clears a flag; zero keeps.
// - Flags read zero until set, then hold.
// - Mask one blocks; masks reset to ones.
// - Edge flag and mask bits 7:6 always read zero.
// - Power-on reset restores all six registers.
`timescale 1ns/1ps
`include "rpgi_consts.vh"
module rpgi_top (
    // Clock and reset.
    input  wire                     clk_i,
    input  wire                     rst_i,
    // Register port.
    input  wire [`RPGI_AW-1:0]      addr_i,
    input  wire [`RPGI_DW-1:0]      wdata_i,
    input  wire                     wr_i,
    input  wire                     rd_i,
    output reg  [`RPGI_DW-1:0]      rdata_o,
    // Power-good pins: bits 3:0 bucks 1-4, bits 7:4 ldo 1-4.
    input  wire [`RPGI_FALL_N-1:0]  fall_good_i,
    input  wire [`RPGI_FALL_N-1:0]  fall_enable_i,
    // Power-good pins of ldo 5-10.
    input  wire [`RPGI_EDGE_N-1:0]  edge_good_i,
    // Interrupt outputs.
    output reg                      pgood_irq_o,
    output reg                      irq_o
);
    wire [`RPGI_FALL_N-1:0] fall_lvl;
    wire [`RPGI_FALL_N-1:0] fall_fall;
    wire [`RPGI_EDGE_N-1:0] edge_lvl;
    wire [`RPGI_EDGE_N-1:0] edge_rise;
    wire [`RPGI_EDGE_N-1:0] edge_fall;
    wire [`RPGI_FALL_N-1:0] en_lvl;

    reg  [`RPGI_FALL_N-1:0] fall_flags_q;
    reg  [`RPGI_FALL_N-1:0] fall_flags_d;
    reg  [`RPGI_FALL_N-1:0] fall_masks_q;
    reg  [`RPGI_EDGE_N-1:0] edge_flags_q;
    reg  [`RPGI_EDGE_N-1:0] edge_flags_d;
    reg  [`RPGI_EDGE_N-1:0] edge_masks_q;
    reg  [`RPGI_IRQ_N-1:0]  irq_stat_q;
    reg  [`RPGI_IRQ_N-1:0]  irq_stat_d;
    reg  [`RPGI_IRQ_N-1:0]  irq_mask_q;
    reg  [`RPGI_DW-1:0]     rdata_d;

    wire [`RPGI_FALL_N-1:0] fall_evt;
    wire [`RPGI_EDGE_N-1:0] edge_evt;
    wire                    pgood_req;

    // Mask reset value, held at full width so the narrow upper group can take a slice of it.
    localparam [`RPGI_DW-1:0] MASK_RST = `RPGI_MASK_RST;
    localparam [`RPGI_DW-1:0] FLAG_RST = `RPGI_FLAG_RST;

    // Address match used by every register strobe decode.
    function rpgi_hit;
        input [`RPGI_AW-1:0] a;
        input [`RPGI_AW-1:0] target;
        begin
            rpgi_hit = (a == target);
        end
    endfunction

    // Power-good and enable levels arrive from the analogue side, so they are synchronised.
    rpgi_sync #(.W(`RPGI_FALL_N + `RPGI_EDGE_N + `RPGI_FALL_N)) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({fall_enable_i, edge_good_i, fall_good_i}),
        .level_o ({en_lvl, edge_lvl, fall_lvl})
    );

    rpgi_edge #(.W(`RPGI_FALL_N)) u_fall_edge (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .level_i  (fall_lvl),
        .rise_o   (),
        .fall_o   (fall_fall),
        .primed_o ()
    );

    rpgi_edge #(.W(`RPGI_EDGE_N)) u_edge_edge (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .level_i  (edge_lvl),
        .rise_o   (edge_rise),
        .fall_o   (edge_fall),
        .primed_o ()
    );

    // A regulator that is switched off is expected to lose its output, so its fall is not an event.
    assign fall_evt = fall_fall & en_lvl;
    assign edge_evt = edge_rise | edge_fall;

    // Unmasked flags combine into the power-good request.
    assign pgood_req = (|(fall_flags_q & ~fall_masks_q)) | (|(edge_flags_q & ~edge_masks_q));

    // Flag next values: an event in the clearing cycle wins so it is never lost.
    always @*
    begin
        fall_flags_d = fall_flags_q;
        edge_flags_d = edge_flags_q;
        if (wr_i && rpgi_hit(addr_i, `RPGI_ADDR_FALL_FLAGS))
            fall_flags_d = fall_flags_q & ~wdata_i[`RPGI_FALL_N-1:0];
        if (wr_i && rpgi_hit(addr_i, `RPGI_ADDR_EDGE_FLAGS))
            edge_flags_d = edge_flags_q & ~wdata_i[`RPGI_EDGE_N-1:0];
        fall_flags_d = fall_flags_d | fall_evt;
        edge_flags_d = edge_flags_d | edge_evt;
    end

    // Sticky summary status: bit 0 for fall flags, bit 1 for edge flags; a read clears it.
    always @*
    begin
        irq_stat_d = irq_stat_q;
        if (rd_i && rpgi_hit(addr_i, `RPGI_ADDR_IRQ_STAT))
            irq_stat_d = {`RPGI_IRQ_N{1'b0}};
        irq_stat_d[`RPGI_IRQ_FALL_BIT] = irq_stat_d[`RPGI_IRQ_FALL_BIT] | (|fall_evt);
        irq_stat_d[`RPGI_IRQ_EDGE_BIT] = irq_stat_d[`RPGI_IRQ_EDGE_BIT] | (|edge_evt);
    end

    // Read mux; unmapped addresses read zero.
    always @*
    begin
        rdata_d = {`RPGI_DW{1'b0}};
        case (addr_i)
            `RPGI_ADDR_FALL_FLAGS: rdata_d = fall_flags_q;
            `RPGI_ADDR_FALL_MASKS: rdata_d = fall_masks_q;
            `RPGI_ADDR_EDGE_FLAGS: rdata_d = {2'b00, edge_flags_q};
            `RPGI_ADDR_EDGE_MASKS: rdata_d = {2'b00, edge_masks_q};
            `RPGI_ADDR_IRQ_STAT:   rdata_d = {6'h00, irq_stat_q};
            `RPGI_ADDR_IRQ_MASK:   rdata_d = {6'h00, irq_mask_q};
            default:               rdata_d = {`RPGI_DW{1'b0}};
        endcase
    end

    // Register state; synchronous reset stands for power-on reset.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fall_flags_q <= FLAG_RST[`RPGI_FALL_N-1:0];
            edge_flags_q <= FLAG_RST[`RPGI_EDGE_N-1:0];
            fall_masks_q <= MASK_RST[`RPGI_FALL_N-1:0];
            edge_masks_q <= MASK_RST[`RPGI_EDGE_N-1:0];
            irq_stat_q   <= {`RPGI_IRQ_N{1'b0}};
            irq_mask_q   <= {`RPGI_IRQ_N{1'b1}};
            rdata_o      <= {`RPGI_DW{1'b0}};
            pgood_irq_o  <= 1'b0;
            irq_o        <= 1'b0;
        end
        else
        begin
            fall_flags_q <= fall_flags_d;
            edge_flags_q <= edge_flags_d;
            irq_stat_q   <= irq_stat_d;
            if (wr_i && rpgi_hit(addr_i, `RPGI_ADDR_FALL_MASKS))
                fall_masks_q <= wdata_i[`RPGI_FALL_N-1:0];
            if (wr_i && rpgi_hit(addr_i, `RPGI_ADDR_EDGE_MASKS))
                edge_masks_q <= wdata_i[`RPGI_EDGE_N-1:0];
            if (wr_i && rpgi_hit(addr_i, `RPGI_ADDR_IRQ_MASK))
                irq_mask_q <= wdata_i[`RPGI_IRQ_N-1:0];
            rdata_o      <= rd_i ? rdata_d : {`RPGI_DW{1'b0}};
            pgood_irq_o  <= pgood_req;
            irq_o        <= |(irq_stat_q & ~irq_mask_q);
        end
    end
endmodule

// *** testbench/rpgi_top_properties.sv ***
// Port-level assertions for the power-good interrupt block.
`timescale 1ns/1ps
module rpgi_checker (
    // Clock, reset and register port.
    input logic       clk_i,
    input logic       rst_i,
    input logic [7:0] addr_i,
    input logic [7:0] wdata_i,
    input logic       wr_i,
    input logic       rd_i,
    input logic [7:0] rdata_o,
    // Pins and requests.
    input logic [7:0] fall_good_i,
    input logic [7:0] fall_enable_i,
    input logic [5:0] edge_good_i,
    input logic       pgood_irq_o,
    input logic       irq_o
);
    logic [7:0]  m3_q;
    logic [5:0]  m4_q;
    logic [1:0]  ms_q;
    logic [21:0] pins_q;
    logic [3:0]  quiet_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Shadow the masks; count quiet pin cycles, since pin events land several cycles late.
    always @(posedge clk_i)
    begin
        pins_q <= {fall_good_i, fall_enable_i, edge_good_i};
        if (rst_i)
        begin
            m3_q <= 8'hFF;
            m4_q <= 6'h3F;
            ms_q <= 2'h3;
            quiet_q <= 4'h0;
        end
        else
        begin
            quiet_q <= (pins_q != {fall_good_i, fall_enable_i, edge_good_i}) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
            m3_q <= (wr_i && addr_i == 8'h3E) ? wdata_i : m3_q;
            m4_q <= (wr_i && addr_i == 8'h40) ? wdata_i[5:0] : m4_q;
            ms_q <= (wr_i && addr_i == 8'h51) ? wdata_i[1:0] : ms_q;
        end
    end
    sequence s_clear;
        wr_i && addr_i == 8'h3D && wdata_i == 8'hFF && quiet_q > 4'd9;
    endsequence
    sequence s_readback;
        rd_i && addr_i == 8'h3D;
    endsequence
    rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read slot");
    unmapped_zero_a: assert property (rd_i && addr_i < 8'h3D |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    unused_bits_a: assert property (rd_i && (addr_i == 8'h3F || addr_i == 8'h40) |=> rdata_o[7:6] == 2'b00)
        else $error("unused bits not zero");
    fall_mask_rb_a: assert property (rd_i && addr_i == 8'h3E |=> rdata_o == $past(m3_q))
        else $error("fall mask read back wrong");
    edge_mask_rb_a: assert property (rd_i && addr_i == 8'h40 |=> rdata_o == {2'b00, $past(m4_q)})
        else $error("edge mask read back wrong");
    pgood_masked_a: assert property ($past(&{m3_q, m4_q}) && (&{m3_q, m4_q}) |-> !pgood_irq_o)
        else $error("request with all masks set");
    summary_masked_a: assert property ($past(&ms_q) && (&ms_q) |-> !irq_o)
        else $error("summary request while masked");
    flag_clear_a: assert property (s_clear ##2 s_readback |=> rdata_o == 8'h00)
        else $error("flags not cleared by write");
endmodule
bind rpgi_top rpgi_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .fall_good_i(fall_good_i), .fall_enable_i(fall_enable_i),
    .edge_good_i(edge_good_i), .pgood_irq_o(pgood_irq_o), .irq_o(irq_o));

// *** testbench/rpgi_top_tb_top.sv ***
// Self-checking bench for the power-good interrupt block.
`timescale 1ns/1ps
module rpgi_top_tb_top;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic [7:0] fall_good_i = 8'hFF;
    logic [7:0] fall_enable_i = 8'hFF;
    logic [5:0] edge_good_i = 6'h00;
    wire  [7:0] rdata_o;
    wire        pgood_irq_o;
    wire        irq_o;
    int         miscompares = 0;
    int         checked = 0;
    // A 4 ns clock.
    always #2 clk_i = ~clk_i;
    rpgi_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .fall_good_i(fall_good_i), .fall_enable_i(fall_enable_i), .edge_good_i(edge_good_i),
        .pgood_irq_o(pgood_irq_o), .irq_o(irq_o));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so look there.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, e);
    endtask
    // Pins pass a synchroniser, so allow them time to land.
    task automatic pins(input logic [7:0] g, input logic [7:0] en, input logic [5:0] eg);
        @(posedge clk_i);
        fall_good_i <= g;
        fall_enable_i <= en;
        edge_good_i <= eg;
        repeat (12) @(posedge clk_i);
    endtask
    task automatic see_irq(input logic [1:0] e);
        repeat (3) @(posedge clk_i);
        #1 chk({6'h00, pgood_irq_o, irq_o}, {6'h00, e});
    endtask
    task automatic do_reset;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    task automatic rst_vals;
        rd(8'h3D, 8'h00);
        rd(8'h3E, 8'hFF);
        rd(8'h3F, 8'h00);
        rd(8'h40, 8'h3F);
        see_irq(2'b00);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // A hang is cut short well beyond the expected run of about seven hundred cycles.
    initial
    begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        tally_and_finish;
    end
    initial
    begin
        do_reset;
        rst_vals;
        rd(8'h20, 8'h00);
        $display("reset values done");
        for (int i = 0; i < 8; i++)
        begin
            pins(~8'(1 << i), 8'hFF, 6'h00);
            rd(8'h3D, 8'(1 << i));
            wr(8'h3D, 8'h00);
            rd(8'h3D, 8'(1 << i));
            wr(8'h3D, 8'hFF);
            rd(8'h3D, 8'h00);
            pins(8'hFF, 8'hFF, 6'h00);
            rd(8'h3D, 8'h00);
        end
        pins(8'hFF, 8'h00, 6'h00);
        pins(8'h00, 8'h00, 6'h00);
        rd(8'h3D, 8'h00);
        pins(8'hFF, 8'hFF, 6'h00);
        $display("fall flags done");
        for (int i = 0; i < 6; i++)
        begin
            pins(8'hFF, 8'hFF, 6'(1 << i));
            rd(8'h3F, 8'(1 << i));
            wr(8'h3F, 8'hFF);
            pins(8'hFF, 8'hFF, 6'h00);
            rd(8'h3F, 8'(1 << i));
            wr(8'h3F, 8'hFF);
        end
        $display("edge flags done");
        pins(8'hFE, 8'hFF, 6'h00);
        wr(8'h40, 8'hC0);
        rd(8'h40, 8'h00);
        see_irq(2'b00);
        wr(8'h3E, 8'hFE);
        see_irq(2'b10);
        wr(8'h3E, 8'hFF);
        see_irq(2'b00);
        wr(8'h3E, 8'h00);
        wr(8'h3D, 8'h01);
        see_irq(2'b00);
        rd(8'h50, 8'h03);
        wr(8'h51, 8'h01);
        pins(8'hFD, 8'hFF, 6'h00);
        see_irq(2'b10);
        pins(8'hFD, 8'hFF, 6'h01);
        see_irq(2'b11);
        rd(8'h50, 8'h03);
        see_irq(2'b10);
        $display("masks and requests done");
        do_reset;
        rst_vals;
        $display("second reset done");
        tally_and_finish;
    end
endmodule
